// file: bench/host_bus_model.sv
// Purpose: host controller side of the register port
// Assumes: one clock; accesses start just after a rising edge
// Notes: write data is inverted once the strobe has been taken
`default_nettype none
module host_bus_model (
    input wire logic clock_in,
    output logic [3:0] addr_out = 4'h0,
    output logic [15:0] wdata_out = 16'h0000,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    input wire logic [15:0] rdata_in
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        // A second write must not raise the strobe in the step that drops it
        if (wr_out) @(posedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clock_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clock_in);
        rd_out <= 1'b0;
        // Read data stand only in the cycle after the strobe
        @(negedge clock_in);
        d = rdata_in;
        @(posedge clock_in);
    endtask
endmodule // host_bus_model
`default_nettype wire

// file: bench/list_sequence_engine_checker.sv
// Purpose: port level checks of the list sequence engine
// Assumes: single clock domain, async active low reset
// Notes: bound to every instance of the engine
`include "list_seq_defs.vh"
`default_nettype none
module list_sequence_engine_checker (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic soft_reset_in,
    input wire logic [15:0] meas_current_in,
    input wire logic [15:0] rdata_out,
    input wire logic [15:0] out_current_out,
    input wire logic [15:0] out_current_limit_out,
    input wire logic [15:0] out_voltage_out,
    input wire logic [15:0] out_voltage_limit_out,
    input wire logic apply_out,
    input wire logic keypad_lock_out,
    input wire logic range_error_out,
    input wire logic [15:0] ques_status_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    sequence sel_wr_rd;
        wr_in && addr_in == `LS_A_INDEX && wdata_in inside {[1:40]}
        ##1 rd_in && addr_in == `LS_A_INDEX;
    endsequence
    sequence start_wr_rd;
        wr_in && addr_in == `LS_A_START && wdata_in inside {[1:40]}
        ##1 rd_in && addr_in == `LS_A_START;
    endsequence
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not idle");
    a_sel_readback: assert property (sel_wr_rd |=> rdata_out == $past(wdata_in, 2))
        else $error("selector readback wrong");
    a_start_readback: assert property (start_wr_rd |=> rdata_out == $past(wdata_in, 2))
        else $error("start readback wrong");
    a_meas_read: assert property (rd_in && addr_in == `LS_A_MEAS |=> rdata_out == $past(meas_current_in, 2))
        else $error("measured current wrong");
    a_warn_bit: assert property (rd_in && addr_in == `LS_A_MEASX |=> ques_status_out[`LS_QUES_WARN_BIT])
        else $error("warning bit not set");
    a_range_err: assert property (wr_in && addr_in inside {[1:4]} && wdata_in > `LS_VAL_MAX |=> range_error_out)
        else $error("range error missing");
    a_err_cause: assert property (range_error_out |-> $past(wr_in))
        else $error("range error without write");
    a_run_lock: assert property (wr_in && addr_in == `LS_A_RUN && wdata_in[0] && !soft_reset_in |=> keypad_lock_out)
        else $error("run did not lock keypad");
    a_stop_halt: assert property (wr_in && addr_in == `LS_A_RUN && !wdata_in[0] |-> ##[1:2] !keypad_lock_out)
        else $error("stop did not halt");
    a_reset_abort: assert property (soft_reset_in |-> ##[1:2] !keypad_lock_out && !apply_out)
        else $error("reset did not abort run");
endmodule // list_sequence_engine_checker
bind list_sequence_engine list_sequence_engine_checker i_list_sequence_engine_checker (.*);
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self checking bench of the list sequence engine
// Assumes: 250 MHz clock; dwell tick too long to run out here
// Notes: entries are stopped by hand since one tick is 2.5M cycles
`include "list_seq_defs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e; logic x;} row_t;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic [15:0] meas_current_in = 16'h0000;
    wire logic [3:0] addr_in;
    wire logic [15:0] wdata_in, rdata_out, ques_status_out;
    wire logic [15:0] out_current_out, out_current_limit_out;
    wire logic [15:0] out_voltage_out, out_voltage_limit_out;
    wire logic wr_in, rd_in, apply_out, keypad_lock_out, range_error_out;
    int error_cnt = 0;
    int checks = 0;
    logic [15:0] got;
    // Entry 21 is filled first, then refused writes must leave it alone
    row_t rows [14] = '{'{`LS_A_INDEX, 16'h0015, 16'h0015, 1'b0},
        '{`LS_A_CURR, 16'h00eb, 16'h00eb, 1'b0}, '{`LS_A_CPROT, 16'h0a70, 16'h0a70, 1'b0},
        '{`LS_A_VOLT, 16'h0100, 16'h0100, 1'b0}, '{`LS_A_VPROT, 16'h0200, 16'h0200, 1'b0},
        '{`LS_A_DWELL, 16'h0001, 16'h0001, 1'b0}, '{`LS_A_NEXT, 16'h0000, 16'h0000, 1'b0},
        '{`LS_A_START, 16'h0015, 16'h0015, 1'b0}, '{`LS_A_INDEX, 16'h0000, 16'h0015, 1'b0},
        '{`LS_A_INDEX, 16'h0029, 16'h0015, 1'b0}, '{`LS_A_NEXT, 16'h0029, 16'h0000, 1'b0},
        '{`LS_A_DWELL, 16'h7531, 16'h0001, 1'b0}, '{`LS_A_CURR, 16'hfa01, 16'h00eb, 1'b1},
        '{`LS_A_VPROT, 16'hfa01, 16'h0200, 1'b1}};
    always #2 clock_in = ~clock_in;
    list_sequence_engine i_list_sequence_engine (.*);
    host_bus_model i_host_bus_model (.clock_in(clock_in), .addr_out(addr_in),
        .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in), .rdata_in(rdata_out));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] e);
        i_host_bus_model.rd(a, got);
        chk(what, got, e);
    endtask
    task automatic run(input logic [15:0] start);
        i_host_bus_model.wr(`LS_A_START, start);
        i_host_bus_model.wr(`LS_A_RUN, 16'h0001);
        repeat (2) @(posedge clock_in);
        #1;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (4) @(posedge clock_in);
        arst_n_in <= 1'b1;
        @(posedge clock_in);
        // The voltage limit rows stay above the entry voltage
        foreach (rows[i]) begin
            i_host_bus_model.wr(rows[i].a, rows[i].d);
            #1 chk("range error", {15'h0000, range_error_out}, {15'h0000, rows[i].x});
            rdchk("readback", rows[i].a, rows[i].e);
        end
        run(16'h0015);
        chk("apply", {15'h0000, apply_out}, 16'h0001);
        chk("current", out_current_out, 16'h00eb);
        chk("current limit", out_current_limit_out, 16'h0a70);
        chk("voltage limit", out_voltage_limit_out, 16'h0200);
        chk("lock", {15'h0000, keypad_lock_out}, 16'h0001);
        chk("voltage", out_voltage_out, 16'h0100);
        rdchk("run state", `LS_A_RUN, 16'h0001);
        i_host_bus_model.wr(`LS_A_RUN, 16'h0000);
        rdchk("stopped", `LS_A_RUN, 16'h0000);
        // Entry 22 has zero dwell and no successor: the run ends at once
        i_host_bus_model.wr(`LS_A_INDEX, 16'h0016);
        i_host_bus_model.wr(`LS_A_DWELL, 16'h0000);
        i_host_bus_model.wr(`LS_A_NEXT, 16'h0000);
        run(16'h0016);
        repeat (5) @(posedge clock_in);
        rdchk("chain end", `LS_A_RUN, 16'h0000);
        run(16'h0015);
        meas_current_in <= 16'h1234;
        soft_reset_in <= 1'b1;
        @(posedge clock_in);
        soft_reset_in <= 1'b0;
        rdchk("abort", `LS_A_RUN, 16'h0000);
        chk("unlock", {15'h0000, keypad_lock_out}, 16'h0000);
        rdchk("measure", `LS_A_MEAS, 16'h1234);
        rdchk("measure extra", `LS_A_MEASX, 16'h1234);
        chk("warning", ques_status_out & 16'h2000, 16'h2000);
        rdchk("status", `LS_A_STATUS, 16'h2000);
        rdchk("status clear", `LS_A_STATUS, 16'h0000);
        arst_n_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        arst_n_in <= 1'b1;
        @(posedge clock_in);
        i_host_bus_model.wr(`LS_A_INDEX, 16'h0015);
        rdchk("retained", `LS_A_CURR, 16'h00eb);
        results();
    end
endmodule // tb_top
`default_nettype wire

// file: inc/list_seq_defs.vh
// Purpose: constants for the list sequence engine
// Assumes: 250 MHz system clock
// Notes: values are raw binary codes; text formatting is done upstream
`ifndef LIST_SEQ_DEFS_VH
`define LIST_SEQ_DEFS_VH
`define LS_ENTRIES 6'd40
`define LS_CLK_HZ 250000000
`define LS_TICK_MS 10
`define LS_TICK_CYC ((`LS_CLK_HZ / 1000) * `LS_TICK_MS)
`define LS_DWELL_MAX 16'd30000
`define LS_A_INDEX 4'h0
`define LS_A_CURR 4'h1
`define LS_A_CPROT 4'h2
`define LS_A_VOLT 4'h3
`define LS_A_VPROT 4'h4
`define LS_A_DWELL 4'h5
`define LS_A_NEXT 4'h6
`define LS_A_START 4'h7
`define LS_A_RUN 4'h8
`define LS_A_MEAS 4'h9
`define LS_A_MEASX 4'ha
`define LS_A_STATUS 4'hb
`define LS_ERR_RANGE 16'hff22
`define LS_QUES_WARN_BIT 13
`define LS_VAL_MAX 16'hfa00
`define LS_RST_INDEX 6'd1
`define LS_RST_START 6'd1
`endif

// file: rtl/list_sequence_engine.v
// Purpose: list sequence store and executor for a programmable source
// Assumes: register port decoded from host text commands upstream
// Notes: entry storage is retained state (no reset of the arrays)
//        a refused write leaves the stored value untouched
//        a stop or reset command always wins over a run command
//        settings outputs hold the last applied entry after a stop
//        a ring of zero-dwell entries ends after forty hops
//
// Behaviour
// - Selector picks one of forty entries
// - Selector is retained across power cycles; reset here reloads entry 1
// - Current write stores into selected entry
// - Out of range value posts error -222
// - Current limit stored separately per entry
// - Voltage write stores into selected entry
// - Voltage limit write stores into entry
// - All entry values are retained
// - Entry queries return selected entry values
// - Dwell accepted from 0.01 to 300 s
// - Zero dwell entries are skipped
// - Next pointer 0 to 40 per entry
// - Next pointer zero ends and stops run
// - Retained start pointer 1 to 40; reset here reloads entry 1
// - Start query returns stored start entry
// - Next query returns selected entry pointer
// - Selector query returns selected entry number
// - Apply entry for dwell then follow pointer
// - Run starts at start, stop halts
// - Measure query returns measured output current
// - Extra measure arguments set warning bit 13
// - Keypad locked while running; reset aborts
// - Run state query returns 1 or 0
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "list_seq_defs.vh"
`default_nettype none

module list_sequence_engine (
    input wire clock_in,
    input wire arst_n_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire soft_reset_in,
    input wire [15:0] meas_current_in,
    output reg [15:0] rdata_out,
    output reg [15:0] out_current_out,
    output reg [15:0] out_current_limit_out,
    output reg [15:0] out_voltage_out,
    output reg [15:0] out_voltage_limit_out,
    output reg apply_out,
    output reg keypad_lock_out,
    output reg range_error_out,
    output reg [15:0] ques_status_out
);

    // ************************************************
    // Retained entry storage
    // ************************************************
    // Index 0 unused; entries are numbered 1..40
    reg [15:0] curr_mem [0:40];
    reg [15:0] cprot_mem [0:40];
    reg [15:0] volt_mem [0:40];
    reg [15:0] vprot_mem [0:40];
    reg [15:0] dwell_mem [0:40];
    reg [5:0] next_mem [0:40];

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_LOAD = 2'd1;
    localparam [1:0] ST_DWELL = 2'd2;

    reg [5:0] sel_q;
    reg [5:0] start_q;
    reg [1:0] state_q;
    reg [5:0] cur_q;
    reg [15:0] dwell_q;
    reg [23:0] tick_q;
    reg [5:0] hops_q;
    reg [15:0] meas_q;

    wire wr_value = wr_in && (addr_in == `LS_A_CURR ||
        addr_in == `LS_A_CPROT || addr_in == `LS_A_VOLT ||
        addr_in == `LS_A_VPROT);
    wire value_bad = wdata_in > `LS_VAL_MAX;
    wire sel_ok = wdata_in != 16'h0000 && wdata_in <= {10'h000, `LS_ENTRIES};
    wire next_ok = wdata_in <= {10'h000, `LS_ENTRIES};
    wire dwell_ok = wdata_in <= `LS_DWELL_MAX;
    wire running = state_q != ST_IDLE;
    // 24 bits hold the cycle count of one 10 ms tick
    localparam integer TICK_LAST_INT = `LS_TICK_CYC - 1;
    localparam [23:0] TICK_LAST = TICK_LAST_INT[23:0];
    wire tick_done = tick_q == TICK_LAST;

    // Per-address strobes
    wire wr_index = wr_in && addr_in == `LS_A_INDEX;
    wire wr_curr = wr_in && addr_in == `LS_A_CURR;
    wire wr_cprot = wr_in && addr_in == `LS_A_CPROT;
    wire wr_volt = wr_in && addr_in == `LS_A_VOLT;
    wire wr_vprot = wr_in && addr_in == `LS_A_VPROT;
    wire wr_dwell = wr_in && addr_in == `LS_A_DWELL;
    wire wr_next = wr_in && addr_in == `LS_A_NEXT;
    wire wr_start = wr_in && addr_in == `LS_A_START;
    wire rd_measx = rd_in && addr_in == `LS_A_MEASX;
    wire rd_status = rd_in && addr_in == `LS_A_STATUS;
    wire stop_req = soft_reset_in ||
        (wr_in && addr_in == `LS_A_RUN && !wdata_in[0]);

    // Entry becomes active: outputs take its settings in this cycle
    wire load_entry = state_q == ST_LOAD && !stop_req &&
        cur_q != 6'd0 && hops_q != `LS_ENTRIES &&
        dwell_mem[cur_q] != 16'h0000;

    // ************************************************
    // Entry writes
    // ************************************************
    // Arrays stand for non-volatile memory, so reset leaves them alone.
    // A refused value keeps the old content, so one bad word cannot
    // wipe a step that was programmed earlier.
    always @(posedge clock_in) begin
        if (wr_curr && !value_bad) begin
            curr_mem[sel_q] <= wdata_in;
        end
    end

    always @(posedge clock_in) begin
        if (wr_cprot && !value_bad) begin
            cprot_mem[sel_q] <= wdata_in;
        end
    end

    always @(posedge clock_in) begin
        if (wr_volt && !value_bad) begin
            volt_mem[sel_q] <= wdata_in;
        end
    end

    always @(posedge clock_in) begin
        if (wr_vprot && !value_bad) begin
            vprot_mem[sel_q] <= wdata_in;
        end
    end

    // ************************************************
    // Dwell and pointer writes
    // ************************************************
    // Dwell 0 is legal and marks an entry to be skipped
    always @(posedge clock_in) begin
        if (wr_dwell && dwell_ok) begin
            dwell_mem[sel_q] <= wdata_in;
        end
    end

    always @(posedge clock_in) begin
        if (wr_next && next_ok) begin
            next_mem[sel_q] <= wdata_in[5:0];
        end
    end

    // ************************************************
    // Selector and start pointer
    // ************************************************
    // Reset value models the retained power-up content of these cells
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_q <= `LS_RST_INDEX;
        end else if (wr_index && sel_ok) begin
            sel_q <= wdata_in[5:0];
        end
    end

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_q <= `LS_RST_START;
        end else if (wr_start && sel_ok) begin
            start_q <= wdata_in[5:0];
        end
    end

    // ************************************************
    // Error flag
    // ************************************************
    // One pulse per refused current, voltage or limit value; the host turns it into the -222 entry
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            range_error_out <= 1'b0;
        end else begin
            range_error_out <= wr_value && value_bad;
        end
    end

    // ************************************************
    // Measurement and status
    // ************************************************
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meas_q <= 16'h0000;
        end else begin
            meas_q <= meas_current_in;
        end
    end

    // The warning bit is sticky until the status word is read.
    // Set and clear come from different addresses, so never collide.
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ques_status_out <= 16'h0000;
        end else if (rd_measx) begin
            ques_status_out[`LS_QUES_WARN_BIT] <= 1'b1;
        end else if (rd_status) begin
            ques_status_out <= 16'h0000;
        end
    end

    // ************************************************
    // Sequence executor
    // ************************************************
    // hops_q bounds a chain of all-zero dwells so the walk cannot spin
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            cur_q <= 6'd0;
            dwell_q <= 16'h0000;
            tick_q <= 24'h000000;
            hops_q <= 6'd0;
            apply_out <= 1'b0;
            keypad_lock_out <= 1'b0;
        end else if (stop_req) begin
            state_q <= ST_IDLE;
            apply_out <= 1'b0;
            keypad_lock_out <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_in && addr_in == `LS_A_RUN) begin
                        cur_q <= start_q;
                        hops_q <= 6'd0;
                        state_q <= ST_LOAD;
                        keypad_lock_out <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    if (cur_q == 6'd0 || hops_q == `LS_ENTRIES) begin
                        state_q <= ST_IDLE;
                        apply_out <= 1'b0;
                        keypad_lock_out <= 1'b0;
                    end else if (dwell_mem[cur_q] == 16'h0000) begin
                        cur_q <= next_mem[cur_q];
                        hops_q <= hops_q + 6'd1;
                    end else begin
                        apply_out <= 1'b1;
                        dwell_q <= dwell_mem[cur_q];
                        tick_q <= 24'h000000;
                        hops_q <= 6'd0;
                        state_q <= ST_DWELL;
                    end
                end
                ST_DWELL: begin
                    if (tick_done) begin
                        tick_q <= 24'h000000;
                        if (dwell_q == 16'h0001) begin
                            cur_q <= next_mem[cur_q];
                            state_q <= ST_LOAD;
                        end else begin
                            dwell_q <= dwell_q - 16'h0001;
                        end
                    end else begin
                        tick_q <= tick_q + 24'h000001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************
    // Read port
    // ************************************************
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `LS_A_INDEX: begin
                    rdata_out <= {10'h000, sel_q};
                end
                `LS_A_CURR: begin
                    rdata_out <= curr_mem[sel_q];
                end
                `LS_A_CPROT: begin
                    rdata_out <= cprot_mem[sel_q];
                end
                `LS_A_VOLT: begin
                    rdata_out <= volt_mem[sel_q];
                end
                `LS_A_VPROT: begin
                    rdata_out <= vprot_mem[sel_q];
                end
                `LS_A_DWELL: begin
                    rdata_out <= dwell_mem[sel_q];
                end
                `LS_A_NEXT: begin
                    rdata_out <= {10'h000, next_mem[sel_q]};
                end
                `LS_A_START: begin
                    rdata_out <= {10'h000, start_q};
                end
                `LS_A_RUN: begin
                    rdata_out <= {15'h0000, running};
                end
                // Registered sample: the value is one cycle old
                `LS_A_MEAS: begin
                    rdata_out <= meas_q;
                end
                // Extra arguments are ignored; only the flag records them
                `LS_A_MEASX: begin
                    rdata_out <= meas_q;
                end
                `LS_A_STATUS: begin
                    rdata_out <= ques_status_out;
                end
                default: begin
                    rdata_out <= 16'h0000;
                end
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    // ************************************************
    // Applied settings
    // ************************************************
    // Held after a stop, so the output keeps the last step until the
    // analog side is told otherwise.
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_current_out <= 16'h0000;
            out_current_limit_out <= 16'h0000;
            out_voltage_out <= 16'h0000;
            out_voltage_limit_out <= 16'h0000;
        end else if (load_entry) begin
            out_current_out <= curr_mem[cur_q];
            out_current_limit_out <= cprot_mem[cur_q];
            out_voltage_out <= volt_mem[cur_q];
            out_voltage_limit_out <= vprot_mem[cur_q];
        end
    end

endmodule // list_sequence_engine
`default_nettype wire
